/* File: shared/otg_session_pkg.sv */
/*
  Constants for the OTG session control block: register offset, field
  positions, reset values and the VBus level codes.
  Assumes a byte-addressed Avalon-MM bus with 32-bit data words.
*/
package otg_session_pkg;

  // Bus geometry
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0]  OFS_SESSION_CTRL = 8'h60;

  // Field positions inside otg_session_control
  localparam int          BIT_ROLE_IS_B    = 7;
  localparam int          BIT_LEVEL_HI     = 4;
  localparam int          BIT_LEVEL_LO     = 3;
  localparam int          BIT_NEG_REQ      = 1;
  localparam int          BIT_SESSION      = 0;

  // Reset values
  localparam logic [7:0]  RST_SESSION_CTRL = 8'h80;
  localparam logic        RST_ROLE_IS_B    = 1'b1;
  localparam logic [1:0]  RST_LEVEL        = 2'h0;

  // VBus level codes
  localparam logic [1:0]  LVL_BELOW_SEND   = 2'h0;
  localparam logic [1:0]  LVL_ABOVE_SEND   = 2'h1;
  localparam logic [1:0]  LVL_ABOVE_A_SIDE_VALID_THRESHOLD = 2'h2;
  localparam logic [1:0]  LVL_ABOVE_VVALID = 2'h3;

  // Unmapped address read value
  localparam logic [31:0] RD_UNMAPPED      = 32'h0000_0000;

endpackage : otg_session_pkg

/* File: design/pin_sync3.sv */
/*
  Three-stage synchroniser for a group of pin levels.
  Assumes inputs are asynchronous to the clock; the output changes only
  once the second and third stages agree.
*/
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // Pins and filtered levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;

  // Shift chain; only s2 reads s1
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a bit only when the two later stages agree
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_reg <= '0;
    end else begin
      for (int k = 0; k < W; k++) begin
        if (s2_reg[k] == s3_reg[k]) begin
          level_reg[k] <= s3_reg[k];
        end
      end
    end
  end

  assign o_level = level_reg;

endmodule : pin_sync3

/* File: design/vbus_level_enc.sv */
/*
  VBus level encoder: turns three comparator levels into the two-bit
  level code and holds it while the transceiver clock is stopped.
  Assumes comparator inputs are already synchronised.
*/
`timescale 1ns/100ps
module vbus_level_enc
  import otg_session_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Comparators and sampling gate
  input  wire logic       i_above_send,
  input  wire logic       i_above_a_side_valid_threshold,
  input  wire logic       i_above_vvalid,
  input  wire logic       i_sample_en,
  // Level code
  output logic [1:0]      o_level
);

  logic [1:0] level_reg;
  logic [1:0] level_next;

  // Highest threshold crossed wins
  always_comb begin
    if (i_above_vvalid) begin
      level_next = LVL_ABOVE_VVALID;
    end else if (i_above_a_side_valid_threshold) begin
      level_next = LVL_ABOVE_A_SIDE_VALID_THRESHOLD;
    end else if (i_above_send) begin
      level_next = LVL_ABOVE_SEND;
    end else begin
      level_next = LVL_BELOW_SEND;
    end
  end

  // Frozen while suspended: no transceiver clock means no sample
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_reg <= RST_LEVEL;
    end else if (i_sample_en) begin
      level_reg <= level_next;
    end
  end

  assign o_level = level_reg;

endmodule : vbus_level_enc

/* File: design/otg_session_control.sv */
/*
  OTG session control register block, device side. Holds the role,
  VBus level, negotiation request and session bits and hands requests
  to the link controller as one-cycle pulses.
  Assumes an Avalon-MM master on I_REF_CLK and a link controller that
  reports suspend, negotiation done and B-side session start/end.
*/
// Contract
// [RQ1] Bit 7 reports role, B=1, resets 1
// [RQ2] Software reads role only during sessions
// [RQ3] Bits 4:3 give VBus level, reset 0
// [RQ4] Codes 1..3 follow comparator thresholds crossed
// [RQ5] Negotiation request starts negotiation at suspend
// [RQ6] Device clears negotiation request when done
// [RQ7] A-device software sets/clears session bit
// [RQ8] B-device sets/clears session bit itself
// [RQ9] B-device write of 1 starts session request
// [RQ10] Clearing session bit in suspend disconnects
// [RQ11] Software never clears session outside suspend
// [RQ12] Bits 6:5 and 2 read zero
// [RQ13] Level code frozen while transceiver suspended
// [RQ14] Read-only fields ignore software writes
`timescale 1ns/100ps
module otg_session_control
  import otg_session_pkg::*;
(
  // Clock and reset
  input  wire logic                  I_REF_CLK,
  input  wire logic                  I_ARST_N,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]     I_AVS_ADDRESS,
  input  wire logic                  I_AVS_READ,
  input  wire logic                  I_AVS_WRITE,
  input  wire logic [DATA_W-1:0]     I_AVS_WRITEDATA,
  input  wire logic [DATA_W/8-1:0]   I_AVS_BYTEENABLE,
  output logic      [DATA_W-1:0]     O_AVS_READDATA,
  output logic                       O_AVS_WAITREQUEST,
  // Link controller status (same clock)
  input  wire logic                  I_SUSPENDED,
  input  wire logic                  I_NEG_DONE,
  input  wire logic                  I_B_SESSION_START,
  input  wire logic                  I_B_SESSION_END,
  // Pins from the OTG transceiver (asynchronous)
  input  wire logic                  I_ROLE_IS_B_PIN,
  input  wire logic                  I_SESSION_END_THRESHOLD,
  input  wire logic                  I_A_SIDE_VALID_THRESHOLD,
  input  wire logic                  I_BUS_POWER_VALID_THRESHOLD,
  // Requests to the link controller
  output logic                       O_NEG_START,
  output logic                       O_SESSION_START_A,
  output logic                       O_SESSION_END_A,
  output logic                       O_SESSION_REQUEST,
  output logic                       O_SOFT_DISCONNECT,
  output logic                       O_SESSION_ACTIVE
);

  // Bus state
  logic        rd_done_reg;
  logic [31:0] rdata_reg;
  logic        wr_hit;
  logic        rd_hit;
  logic        wr_lane0;

  // Register fields
  logic        role_is_b_reg;
  logic        negotiation_request_reg;
  logic        session_reg;
  logic [1:0]  level;

  // Synchronised pin levels
  logic [3:0]  pins_sync;
  logic        role_pin;

  // Suspend edge tracking
  logic        suspended_d_reg;
  logic        suspend_entry;

  // Request pulses
  logic        neg_start_reg;
  logic        sess_start_a_reg;
  logic        sess_end_a_reg;
  logic        sess_req_reg;
  logic        soft_disc_reg;

  // Address decode for the single mapped word
  function automatic logic hits_ctrl(input logic [ADDR_W-1:0] a);
    return a == OFS_SESSION_CTRL;
  endfunction : hits_ctrl

  // Writes finish in one cycle, reads take one extra cycle for data
  assign wr_hit   = I_AVS_WRITE && hits_ctrl(I_AVS_ADDRESS);
  assign rd_hit   = I_AVS_READ && !rd_done_reg;
  assign wr_lane0 = wr_hit && I_AVS_BYTEENABLE[0];
  assign O_AVS_WAITREQUEST = rd_hit;

  // Comparator and role pins pass the three-stage synchroniser.
  // The role pin travels inverted so the chain's all-zero reset state
  // reads as the B-device reset value, not as a false A-device role.
  pin_sync3 #(
    .W (4)
  ) u_pin_sync (
    .i_clk    (I_REF_CLK),
    .i_arst_n (I_ARST_N),
    .i_async  ({!I_ROLE_IS_B_PIN, I_BUS_POWER_VALID_THRESHOLD,
                I_A_SIDE_VALID_THRESHOLD, I_SESSION_END_THRESHOLD}),
    .o_level  (pins_sync)
  );

  assign role_pin = !pins_sync[3]; // RQ1

  // Level code, held while suspended
  vbus_level_enc u_level (
    .i_clk          (I_REF_CLK),
    .i_arst_n       (I_ARST_N),
    .i_above_send   (pins_sync[0]),
    .i_above_a_side_valid_threshold (pins_sync[1]),
    .i_above_vvalid (pins_sync[2]),
    .i_sample_en    (!I_SUSPENDED),  // RQ13
    .o_level        (level)          // RQ3 RQ4
  );

  // Role bit: comes from the ID pin, never from software
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      role_is_b_reg <= RST_ROLE_IS_B; // RQ1
    end else begin
      role_is_b_reg <= role_pin; // RQ1 RQ14
    end
  end

  // Suspend entry detect
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      suspended_d_reg <= 1'b0;
    end else begin
      suspended_d_reg <= I_SUSPENDED;
    end
  end

  assign suspend_entry = I_SUSPENDED && !suspended_d_reg;

  // Negotiation request: a same-cycle software write wins over the
  // done pulse, so a fresh request is never lost to the clear
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      negotiation_request_reg <= RST_SESSION_CTRL[BIT_NEG_REQ];
    end else if (wr_lane0) begin
      negotiation_request_reg <= I_AVS_WRITEDATA[BIT_NEG_REQ];
    end else if (I_NEG_DONE) begin
      negotiation_request_reg <= 1'b0; // RQ6
    end
  end

  // Negotiation starts only on the suspend entry edge; a request made
  // while already suspended waits for the next entry
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      neg_start_reg <= 1'b0;
    end else begin
      neg_start_reg <= negotiation_request_reg && suspend_entry; // RQ5
    end
  end

  // Session bit: software writes on either side, controller also sets/clears on B side
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      session_reg <= RST_SESSION_CTRL[BIT_SESSION];
    end else if (role_is_b_reg && I_B_SESSION_START) begin
      session_reg <= 1'b1; // RQ8
    end else if (wr_lane0) begin
      session_reg <= I_AVS_WRITEDATA[BIT_SESSION]; // RQ7 RQ9 RQ10
    end else if (role_is_b_reg && I_B_SESSION_END) begin
      session_reg <= 1'b0; // RQ8
    end
  end

  // Software-driven session requests as one-cycle pulses
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sess_start_a_reg <= 1'b0;
      sess_end_a_reg   <= 1'b0;
      sess_req_reg     <= 1'b0;
      soft_disc_reg    <= 1'b0;
    end else begin
      sess_start_a_reg <= wr_lane0 && !role_is_b_reg
                          && I_AVS_WRITEDATA[BIT_SESSION]
                          && !session_reg; // RQ7
      sess_end_a_reg   <= wr_lane0 && !role_is_b_reg
                          && !I_AVS_WRITEDATA[BIT_SESSION]
                          && session_reg; // RQ7
      sess_req_reg     <= wr_lane0 && role_is_b_reg
                          && I_AVS_WRITEDATA[BIT_SESSION]; // RQ9
      // Clearing outside suspend is undefined; the bit still clears but no disconnect is raised
      soft_disc_reg    <= wr_lane0 && I_SUSPENDED
                          && !I_AVS_WRITEDATA[BIT_SESSION]
                          && session_reg; // RQ10 RQ11
    end
  end

  // Read data; reserved bits and unmapped words read as zero
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rd_done_reg <= 1'b0;
      rdata_reg   <= RD_UNMAPPED;
    end else if (rd_hit) begin
      rd_done_reg <= 1'b1;
      if (hits_ctrl(I_AVS_ADDRESS)) begin
        rdata_reg <= {24'h000000, role_is_b_reg, 2'h0, level, 1'b0,
                      negotiation_request_reg, session_reg}; // RQ12
      end else begin
        rdata_reg <= RD_UNMAPPED;
      end
    end else begin
      rd_done_reg <= 1'b0;
    end
  end

  assign O_AVS_READDATA    = rdata_reg;
  assign O_NEG_START       = neg_start_reg;
  assign O_SESSION_START_A = sess_start_a_reg;
  assign O_SESSION_END_A   = sess_end_a_reg;
  assign O_SESSION_REQUEST = sess_req_reg;
  assign O_SOFT_DISCONNECT = soft_disc_reg;
  assign O_SESSION_ACTIVE  = session_reg;

endmodule : otg_session_control

/* File: verification/otg_session_assertions.sv */
/*
  Port checks for the OTG session control block.
  Assumes it is bound onto otg_session_control, one clock domain.
*/
`timescale 1ns/100ps
module otg_session_assertions
  import otg_session_pkg::*;
(
  // Clock and reset
  input wire logic              I_REF_CLK,
  input wire logic              I_ARST_N,
  // Bus side
  input wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic              I_AVS_WRITE,
  input wire logic [DATA_W-1:0] I_AVS_WRITEDATA,
  input wire logic [3:0]        I_AVS_BYTEENABLE,
  input wire logic [DATA_W-1:0] O_AVS_READDATA,
  // Link side
  input wire logic              I_SUSPENDED,
  input wire logic              I_B_SESSION_START,
  input wire logic              I_B_SESSION_END,
  input wire logic              O_NEG_START,
  input wire logic              O_SESSION_START_A,
  input wire logic              O_SESSION_END_A,
  input wire logic              O_SESSION_REQUEST,
  input wire logic              O_SOFT_DISCONNECT,
  input wire logic              O_SESSION_ACTIVE
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  logic wr_hit;
  // Write on lane 0 of the mapped register; other writes must do nothing
  assign wr_hit = I_AVS_WRITE && I_AVS_BYTEENABLE[0]
                  && I_AVS_ADDRESS == OFS_SESSION_CTRL;

  a_rsvd_zero: assert property (
    (O_AVS_READDATA & 32'hFFFF_FF64) == 32'h0) else $error("reserved set");
  a_neg_at_suspend: assert property (
    O_NEG_START |-> $past(I_SUSPENDED) && !$past(I_SUSPENDED, 2))
    else $error("negotiation start without suspend entry");
  a_srp_on_write: assert property (
    O_SESSION_REQUEST |-> $past(wr_hit && I_AVS_WRITEDATA[0]))
    else $error("session request without write");
  a_disc_on_clear: assert property (
    O_SOFT_DISCONNECT |-> $past(wr_hit && !I_AVS_WRITEDATA[0] && I_SUSPENDED))
    else $error("disconnect without suspended clear");
  a_start_a_cause: assert property (
    O_SESSION_START_A |-> $past(wr_hit && I_AVS_WRITEDATA[0]
    && !O_SESSION_ACTIVE)) else $error("bad session start");
  a_end_a_cause: assert property (
    O_SESSION_END_A |-> $past(wr_hit && !I_AVS_WRITEDATA[0]
    && O_SESSION_ACTIVE)) else $error("bad session end");
  a_sess_follows_wr: assert property (
    wr_hit && !I_B_SESSION_START |=> O_SESSION_ACTIVE
    == $past(I_AVS_WRITEDATA[0])) else $error("session bit missed write");
  a_sess_hold: assert property (
    !wr_hit && !I_B_SESSION_START && !I_B_SESSION_END
    |=> $stable(O_SESSION_ACTIVE)) else $error("session bit moved alone");
endmodule : otg_session_assertions

bind otg_session_control otg_session_assertions i_otg_session_assertions (
  .I_REF_CLK         (I_REF_CLK),
  .I_ARST_N          (I_ARST_N),
  .I_AVS_ADDRESS     (I_AVS_ADDRESS),
  .I_AVS_WRITE       (I_AVS_WRITE),
  .I_AVS_WRITEDATA   (I_AVS_WRITEDATA),
  .I_AVS_BYTEENABLE  (I_AVS_BYTEENABLE),
  .O_AVS_READDATA    (O_AVS_READDATA),
  .I_SUSPENDED       (I_SUSPENDED),
  .I_B_SESSION_START (I_B_SESSION_START),
  .I_B_SESSION_END   (I_B_SESSION_END),
  .O_NEG_START       (O_NEG_START),
  .O_SESSION_START_A (O_SESSION_START_A),
  .O_SESSION_END_A   (O_SESSION_END_A),
  .O_SESSION_REQUEST (O_SESSION_REQUEST),
  .O_SOFT_DISCONNECT (O_SOFT_DISCONNECT),
  .O_SESSION_ACTIVE  (O_SESSION_ACTIVE)
);

/* File: verification/otg_peer_model.sv */
/*
  Far side of the block: transceiver comparators and a link
  controller that answers negotiation and session requests.
  Assumes the bench sets VBus code, role, suspend and answer delay.
*/
`timescale 1ns/100ps
module otg_peer_model (
  // Clock, reset and bench controls
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [1:0] i_vbus_code,
  input  wire logic [3:0] i_delay,
  // Requests from the block
  input  wire logic       i_neg_start,
  input  wire logic       i_session_request,
  // Answers to the block
  output logic            o_neg_done,
  output logic            o_b_start,
  output logic            o_send,
  output logic            o_a_side_valid_threshold,
  output logic            o_vvalid
);
  logic [3:0] neg_cnt;
  logic [3:0] srp_cnt;
  // Comparators form a thermometer of the VBus level
  assign o_send   = i_vbus_code != 2'h0;
  assign o_a_side_valid_threshold = i_vbus_code[1];
  assign o_vvalid = i_vbus_code == 2'h3;
  // Delay 1 answers promptly, larger values model a slow peer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      neg_cnt    <= 4'h0;
      srp_cnt    <= 4'h0;
      o_neg_done <= 1'b0;
      o_b_start  <= 1'b0;
    end else begin
      o_neg_done <= neg_cnt == 4'h1;
      o_b_start  <= srp_cnt == 4'h1;
      neg_cnt    <= i_neg_start ? i_delay : neg_cnt - (neg_cnt != 4'h0);
      srp_cnt    <= i_session_request ? i_delay : srp_cnt - (srp_cnt != 4'h0);
    end
  end
endmodule : otg_peer_model

/* File: verification/testbench.sv */
/*
  Self-checking bench for otg_session_control with a peer model.
  Assumes the design answers reads one cycle late and writes at once.
*/
`timescale 1ns/100ps
module testbench;
  import otg_session_pkg::*;
  logic clk, rst_n, rd, wr, susp, role_b, neg_done, b_start, s0, s1, s2;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [1:0] vbus;
  logic [3:0] dly;
  logic [4:0] pulses;
  logic neg_s, sa, ea, sreq, disc, act, wreq, b_end;
  int pc[5];
  int error_cnt, n_compared;

  otg_session_control i_otg_session_control (.I_REF_CLK(clk),
    .I_ARST_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .I_SUSPENDED(susp),
    .I_NEG_DONE(neg_done), .I_B_SESSION_START(b_start),
    .I_B_SESSION_END(b_end), .I_ROLE_IS_B_PIN(role_b),
    .I_SESSION_END_THRESHOLD(s0), .I_A_SIDE_VALID_THRESHOLD(s1),
    .I_BUS_POWER_VALID_THRESHOLD(s2), .O_NEG_START(neg_s),
    .O_SESSION_START_A(sa), .O_SESSION_END_A(ea),
    .O_SESSION_REQUEST(sreq), .O_SOFT_DISCONNECT(disc),
    .O_SESSION_ACTIVE(act));
  otg_peer_model i_otg_peer_model (.i_clk(clk), .i_arst_n(rst_n),
    .i_vbus_code(vbus), .i_delay(dly), .i_neg_start(neg_s),
    .i_session_request(sreq), .o_neg_done(neg_done), .o_b_start(b_start),
    .o_send(s0), .o_a_side_valid_threshold(s1), .o_vvalid(s2));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count request pulses so scenarios can judge how many were raised
  assign pulses = {disc, sreq, ea, sa, neg_s};
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) if (pulses[i] === 1'b1) pc[i]++;
  end

  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // Hold the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (n == 20) begin
      error_cnt++;
      finish_test();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic t_level;
    for (int c = 0; c < 4; c++) begin
      vbus <= c[1:0];
      idle(8);
      bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h80 | (c << 3));
    end
    susp <= 1'b1;
    vbus <= 2'h0;
    idle(8);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h98);
    susp <= 1'b0;
    idle(8);
  endtask : t_level
  task automatic t_read_only;
    bus(1, OFS_SESSION_CTRL, 32'hFFFF_FFFC);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h80);
    bus(1, 8'h64, 32'h3);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h80);
    bus(0, 8'h64, 0); check(q, 32'h0);
  endtask : t_read_only
  task automatic t_negotiate;
    dly <= 4'h9;
    bus(1, OFS_SESSION_CTRL, 32'h2);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h82);
    susp <= 1'b1;
    idle(3); check(pc[0], 1);
    idle(12);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h80);
    susp <= 1'b0;
  endtask : t_negotiate
  task automatic t_b_session;
    dly <= 4'h1;
    bus(1, OFS_SESSION_CTRL, 32'h1);
    idle(3); check(pc[3], 1);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h81);
    // Peer ends the session: the block clears the bit by itself
    b_end <= 1'b1;
    idle(1);
    b_end <= 1'b0;
    idle(1);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h80);
    bus(1, OFS_SESSION_CTRL, 32'h1);
    idle(3);
    susp <= 1'b1;
    bus(1, OFS_SESSION_CTRL, 32'h0);
    idle(2); check(pc[4], 1);
    susp <= 1'b0;
  endtask : t_b_session
  task automatic t_a_session;
    role_b <= 1'b0;
    idle(8);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h0);
    // Read-only bits written high must not stick
    bus(1, OFS_SESSION_CTRL, 32'hFD);
    idle(2);
    check(pc[1], 1);
    check(pc[3], 2);
    check({31'h0, act}, 32'h1);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h01);
    susp <= 1'b1;
    bus(1, OFS_SESSION_CTRL, 32'h0);
    idle(2); check(pc[2], 1);
  endtask : t_a_session
  // Reset in mid-run with the role pin low and VBus high
  task automatic t_reset;
    vbus <= 2'h3;
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    idle(1);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h80);
    idle(8);
    bus(0, OFS_SESSION_CTRL, 0); check(q, 32'h0);
  endtask : t_reset

  initial begin
    {rd, wr, susp, b_end, addr, wdata, vbus, dly} = '0;
    role_b = 1'b1;
    rst_n = 1'b0;
    idle(20);
    rst_n <= 1'b1;
    idle(8);
    t_level();
    t_read_only();
    t_negotiate();
    t_b_session();
    t_a_session();
    t_reset();
    finish_test();
  end
endmodule : testbench
